// ===== hdl/sto_io_consts.svh
/*
  Timing constants for the safe torque off input and monitor logic.
  Assumes a 20 MHz system clock; included by bare name.
*/
`ifndef STO_IO_CONSTS_SVH
`define STO_IO_CONSTS_SVH

`define STO_CLK_PERIOD_NS 50
`define STO_TEST_PULSE_MAX_US 1000
`define STO_TEST_PULSE_CYCLES ((`STO_TEST_PULSE_MAX_US * 1000) / `STO_CLK_PERIOD_NS)
`define STO_FILT_W 15
`define STO_RUN_HOLD_CYCLES 15'h0002
`define STO_SYNC_RESET 2'h0
`define STO_MON_RESET 3'h7

`endif

// ===== hdl/sto_io_pkg.sv
/*
  Types shared by the safe torque off input and monitor logic.
  Assumes no other package is needed.
*/
package sto_io_pkg;

  typedef struct packed {
    logic monitorA;
    logic monitorB;
    logic monitorSeries;
  } sto_monitor_s;

  typedef enum logic [2:0] {
    STO_SHUTOFF = 3'b001,
    STO_RELEASE = 3'b010,
    STO_FAULT = 3'b100
  } sto_state_e;

endpackage : sto_io_pkg

// ===== hdl/sto_io_logic.sv
/*
  Safe torque off input and monitor logic: synchronises both safety channels,
  drives the per-channel and series monitor outputs, the base drive release,
  and the timing alarm with dynamic brake request.
  Assumes the safety channels arrive as asynchronous pin levels, high meaning
  the channel is closed to its common, and that motor running, torque mode and
  the forced stop input come from logic on the same clock.
  Synchroniser and monitor reset values come from the constants header, which must be on the include
  path of every tool that reads this file.
*/
`timescale 1ns/10ps
`default_nettype none
`include "sto_io_consts.svh"

module sto_io_logic
  import sto_io_pkg::*;
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic safetyInputA,
  input wire logic safetyInputB,
  input wire logic forcedStopDecelInput,
  input wire logic motorRunning,
  input wire logic torqueMode,
  input wire logic alarmReset,
  output var sto_monitor_s shutoffMonitor,
  output logic driveRelease,
  output logic dynamicBrake,
  output logic forcedStopDecel,
  output logic shutoffTimingAlarm
);

  logic [1:0] syncA_reg;
  logic [1:0] syncB_reg;
  sto_state_e state_reg;
  sto_state_e state_next;
  sto_monitor_s monitor_next;
  logic alarm_next;

  // Each channel passes two flip-flops; only the second stage is read.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      syncA_reg <= `STO_SYNC_RESET;
      syncB_reg <= `STO_SYNC_RESET;
    end else begin
      syncA_reg <= {syncA_reg[0], safetyInputA};
      syncB_reg <= {syncB_reg[0], safetyInputB};
    end
  end

  wire logic chanAClosed = syncA_reg[1];
  wire logic chanBClosed = syncB_reg[1];
  wire logic bothClosed = chanAClosed & chanBClosed;
  // A channel opening while the motor still turns is a timing fault; a short
  // test pulse is treated the same, since no fault may be masked by filtering.
  wire logic openWhileRunning = ~bothClosed & motorRunning;

  wire logic monANext = ~chanAClosed;
  wire logic monBNext = ~chanBClosed;
  wire logic monSeriesNext = ~chanAClosed & ~chanBClosed;
  assign monitor_next = '{monitorA: monANext, monitorB: monBNext, monitorSeries: monSeriesNext};

  // Clearing is refused while the motor turns, so a reset pressed early
  // cannot let a running axis slip back towards the release state.
  wire logic alarmClear = alarmReset & ~motorRunning;

  // The alarm latches and only clears on an alarm reset with the motor stopped.
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      STO_SHUTOFF: begin
        if (bothClosed) begin
          state_next = STO_RELEASE;
        end
      end
      STO_RELEASE: begin
        if (openWhileRunning) begin
          state_next = STO_FAULT;
        end else if (!bothClosed) begin
          state_next = STO_SHUTOFF;
        end
      end
      STO_FAULT: begin
        if (alarmClear) begin
          state_next = STO_SHUTOFF;
        end
      end
      default: begin
        state_next = STO_SHUTOFF;
      end
    endcase
  end

  assign alarm_next = (state_next == STO_FAULT);
  wire logic releaseNext = (state_next == STO_RELEASE);

  // Every output is registered, so the monitor contacts, the drive release
  // and the alarm all switch on the same edge and never glitch at the pins.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= STO_SHUTOFF;
      shutoffMonitor <= sto_monitor_s'(`STO_MON_RESET);
      driveRelease <= 1'b0;
      dynamicBrake <= 1'b0;
      forcedStopDecel <= 1'b0;
      shutoffTimingAlarm <= 1'b0;
    end else begin
      state_reg <= state_next;
      shutoffMonitor <= monitor_next;
      driveRelease <= releaseNext;
      dynamicBrake <= alarm_next;
      forcedStopDecel <= ~forcedStopDecelInput & ~torqueMode;
      shutoffTimingAlarm <= alarm_next;
    end
  end

  // Outputs lag their inputs by one edge, so most checks look one edge on.
  property p_monA;
    @(posedge mclk) disable iff (!arst_n)
      ##1 shutoffMonitor.monitorA == !$past(chanAClosed);
  endproperty
  a_monA: assert property (p_monA) else $error("monitor A wrong");

  property p_monB;
    @(posedge mclk) disable iff (!arst_n)
      ##1 shutoffMonitor.monitorB == !$past(chanBClosed);
  endproperty
  a_monB: assert property (p_monB) else $error("monitor B wrong");

  property p_series;
    @(posedge mclk) disable iff (!arst_n)
      shutoffMonitor.monitorSeries == (shutoffMonitor.monitorA && shutoffMonitor.monitorB);
  endproperty
  a_series: assert property (p_series) else $error("series monitor wrong");

  property p_release;
    @(posedge mclk) disable iff (!arst_n)
      driveRelease |-> shutoffMonitor.monitorA == 1'b0 && shutoffMonitor.monitorB == 1'b0;
  endproperty
  a_release: assert property (p_release) else $error("release with open channel");

  property p_openStops;
    @(posedge mclk) disable iff (!arst_n)
      !bothClosed |=> !driveRelease;
  endproperty
  a_openStops: assert property (p_openStops) else $error("open channel kept drive");

  property p_alarm;
    @(posedge mclk) disable iff (!arst_n)
      (state_reg == STO_RELEASE) && openWhileRunning |=> shutoffTimingAlarm && dynamicBrake;
  endproperty
  a_alarm: assert property (p_alarm) else $error("timing alarm missed");

  property p_torque;
    @(posedge mclk) disable iff (!arst_n)
      $past(torqueMode) |-> !forcedStopDecel;
  endproperty
  a_torque: assert property (p_torque) else $error("decel in torque mode");

  property p_sync;
    @(posedge mclk) disable iff (!arst_n)
      $rose(safetyInputA) ##1 safetyInputA ##1 safetyInputA |-> ##1 !shutoffMonitor.monitorA;
  endproperty
  a_sync: assert property (p_sync) else $error("sync latency wrong");

  // A slip on one channel alone would split the two monitor contacts apart.
  property p_syncB;
    @(posedge mclk) disable iff (!arst_n)
      $rose(safetyInputB) ##1 safetyInputB ##1 safetyInputB |-> ##1 !shutoffMonitor.monitorB;
  endproperty
  a_syncB: assert property (p_syncB) else $error("sync latency wrong on B");

  property p_alarmHold;
    @(posedge mclk) disable iff (!arst_n)
      shutoffTimingAlarm && !(alarmReset && !motorRunning) |=> shutoffTimingAlarm;
  endproperty
  a_alarmHold: assert property (p_alarmHold) else $error("timing alarm dropped");

  property p_alarmClear;
    @(posedge mclk) disable iff (!arst_n)
      shutoffTimingAlarm && alarmReset && !motorRunning |=> !shutoffTimingAlarm && !driveRelease;
  endproperty
  a_alarmClear: assert property (p_alarmClear) else $error("timing alarm not cleared");

  property p_brakeNoDrive;
    @(posedge mclk) disable iff (!arst_n)
      dynamicBrake |-> !driveRelease && shutoffTimingAlarm;
  endproperty
  a_brakeNoDrive: assert property (p_brakeNoDrive) else $error("brake with drive released");

  property p_decel;
    @(posedge mclk) disable iff (!arst_n)
      ##1 forcedStopDecel == (!$past(forcedStopDecelInput) && !$past(torqueMode));
  endproperty
  a_decel: assert property (p_decel) else $error("forced stop decel wrong");

  property p_noAlarmStopped;
    @(posedge mclk) disable iff (!arst_n)
      (state_reg == STO_RELEASE) && !motorRunning |=> !shutoffTimingAlarm;
  endproperty
  a_noAlarmStopped: assert property (p_noAlarmStopped) else $error("alarm with motor stopped");

  property p_releaseEntry;
    @(posedge mclk) disable iff (!arst_n)
      (state_reg == STO_SHUTOFF) && bothClosed |=> driveRelease;
  endproperty
  a_releaseEntry: assert property (p_releaseEntry) else $error("drive not released");

  property p_shutoffKeep;
    @(posedge mclk) disable iff (!arst_n)
      (state_reg == STO_SHUTOFF) && !bothClosed |=> !driveRelease && !shutoffTimingAlarm;
  endproperty
  a_shutoffKeep: assert property (p_shutoffKeep) else $error("shut-off state left early");

  property p_faultNoRelease;
    @(posedge mclk) disable iff (!arst_n)
      (state_reg == STO_FAULT) |=> !driveRelease;
  endproperty
  a_faultNoRelease: assert property (p_faultNoRelease) else $error("drive released in fault");

endmodule : sto_io_logic
`default_nettype wire

// ===== tb/sto_relay_model.sv
/* Safety relay model driving both channel pin levels.
   Assumes open commands from the bench on mclk. */
`timescale 1ns/10ps
`default_nettype none
module sto_relay_model (
  input wire logic mclk,
  input wire logic openA,
  input wire logic openB,
  output logic safetyInputA,
  output logic safetyInputB
);
  // The bench opens channels singly and together, with the motor running only
  // in the alarm test, and pulses channel A once in the pulse test.
  always_ff @(posedge mclk) begin
    safetyInputA <= ~openA;
    safetyInputB <= ~openB;
  end
endmodule : sto_relay_model
`default_nettype wire

// ===== tb/testbench.sv
/* Self-checking bench for the safe torque off logic.
   Assumes the relay model and the design are compiled first. */
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import sto_io_pkg::*;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic openA = 1'b1;
  logic openB = 1'b1;
  logic fsIn = 1'b1;
  logic motorRunning = 1'b0;
  logic torqueMode = 1'b0;
  logic alarmReset = 1'b0;
  logic safetyInputA, safetyInputB;
  sto_monitor_s mon;
  logic driveRelease, dynamicBrake, forcedStopDecel, alarm;
  int failures = 0;
  int num_checks = 0;
  always #25 mclk = ~mclk;
  sto_relay_model sto_relay_model_i (.mclk(mclk), .openA(openA), .openB(openB),
    .safetyInputA(safetyInputA), .safetyInputB(safetyInputB));
  sto_io_logic sto_io_logic_i (.mclk(mclk), .arst_n(arst_n), .safetyInputA(safetyInputA),
    .safetyInputB(safetyInputB), .forcedStopDecelInput(fsIn), .motorRunning(motorRunning),
    .torqueMode(torqueMode), .alarmReset(alarmReset), .shutoffMonitor(mon),
    .driveRelease(driveRelease), .dynamicBrake(dynamicBrake),
    .forcedStopDecel(forcedStopDecel), .shutoffTimingAlarm(alarm));
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge mclk);
      #1;
    end
  endtask : tick
  task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic complete_run;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : complete_run
  // One model edge plus three design edges; five leaves margin.
  task automatic pins(input logic a, input logic b);
    openA = a;
    openB = b;
    tick(5);
  endtask : pins
  task automatic t_channels;
    pins(1'b0, 1'b0);
    chk({1'b0, mon}, 4'h0);
    chk({3'h0, driveRelease}, 4'h1);
    pins(1'b1, 1'b0);
    chk({1'b0, mon}, 4'h4);
    chk({3'h0, driveRelease}, 4'h0);
    pins(1'b0, 1'b1);
    chk({1'b0, mon}, 4'h2);
    chk({3'h0, driveRelease}, 4'h0);
    pins(1'b1, 1'b1);
    chk({1'b0, mon}, 4'h7);
    $display("test channels done");
  endtask : t_channels
  task automatic t_alarm;
    pins(1'b0, 1'b0);
    motorRunning = 1'b1;
    pins(1'b1, 1'b1);
    chk({1'b0, dynamicBrake, alarm, driveRelease}, 4'h6);
    pins(1'b0, 1'b0);
    chk({2'h0, alarm, driveRelease}, 4'h2);
    alarmReset = 1'b1;
    tick(2);
    chk({1'b0, dynamicBrake, alarm, driveRelease}, 4'h6);
    motorRunning = 1'b0;
    tick(1);
    alarmReset = 1'b0;
    tick(4);
    chk({1'b0, dynamicBrake, alarm, driveRelease}, 4'h1);
    $display("test alarm done");
  endtask : t_alarm
  task automatic t_decel;
    fsIn = 1'b0;
    tick(2);
    chk({3'h0, forcedStopDecel}, 4'h1);
    torqueMode = 1'b1;
    tick(2);
    chk({3'h0, forcedStopDecel}, 4'h0);
    fsIn = 1'b1;
    torqueMode = 1'b0;
    $display("test decel done");
  endtask : t_decel
  // A three-cycle diagnostic pulse, far inside the off-time limit, with the
  // motor stopped: drive drops for the pulse and returns with no alarm.
  task automatic t_pulse;
    openA = 1'b1;
    tick(3);
    openA = 1'b0;
    tick(2);
    chk({1'b0, mon}, 4'h4);
    chk({1'b0, dynamicBrake, alarm, driveRelease}, 4'h0);
    tick(3);
    chk({1'b0, mon}, 4'h0);
    chk({3'h0, driveRelease}, 4'h1);
    $display("test pulse done");
  endtask : t_pulse
  task automatic t_reset;
    arst_n = 1'b0;
    tick(2);
    chk({1'b0, mon}, 4'h7);
    chk({1'b0, dynamicBrake, alarm, driveRelease}, 4'h0);
    arst_n = 1'b1;
    tick(1);
    chk({1'b0, mon}, 4'h7);
    chk({3'h0, driveRelease}, 4'h0);
    tick(3);
    chk({1'b0, mon}, 4'h0);
    chk({3'h0, driveRelease}, 4'h1);
    $display("test reset done");
  endtask : t_reset
  initial begin
    tick(3);
    arst_n = 1'b1;
    t_channels();
    t_alarm();
    t_pulse();
    t_decel();
    t_reset();
    complete_run();
  end
endmodule : testbench
`default_nettype wire
